// >>> ccu_params.svh
// Register map, field positions, encodings and reset values of the unit
`ifndef CCU_PARAMS_SVH
`define CCU_PARAMS_SVH
// Notes on behaviour
// - Capture copies selected 16-bit timer count
// - Mode picks fall, rise, 4th, 16th, any
// - Capture sets flag; only software clears
// - New capture silently overwrites old value
// - Source select: pin, comparators, pin change, cells
// - Pin level feeds detector even as output
// - Mode change may cause spurious capture
// - Prescaler cleared when off, non-capture, reset
// - Prescaler switch keeps count, may misfire
// - Async-counter timer need not serve unit
// - Capture keeps working in sleep
// - Compare value against selected timer continuously
// - Match action: toggle, set, clear, pulse
// - Match sets flag and conversion trigger
// - Modes 0001 and 1011 clear timer
// - Zero control write forces output latch low
// - Value register reached as two bytes
// - Timer select chooses first, third, fifth

// Byte offsets on the register bus
`define CCU_OFF_CONTROL   8'h00
`define CCU_OFF_VALUE_LOW 8'h04
`define CCU_OFF_VALUE_HI  8'h08
`define CCU_OFF_TSEL      8'h0c
`define CCU_OFF_FLAG      8'h10
`define CCU_OFF_ENABLE    8'h14

// Control register fields
`define CCU_CTL_MODE_MSB  3
`define CCU_CTL_MODE_LSB  0
`define CCU_CTL_ON_BIT    7
`define CCU_CTL_SRC_MSB   11
`define CCU_CTL_SRC_LSB   8

// Reset values
`define CCU_CONTROL_RESET 12'h000
`define CCU_TSEL_RESET    2'h1

// Mode codes
`define CCU_MODE_OFF      4'h0
`define CCU_MODE_TOG_CLR  4'h1
`define CCU_MODE_TOGGLE   4'h2
`define CCU_MODE_CAP_ANY  4'h3
`define CCU_MODE_CAP_FALL 4'h4
`define CCU_MODE_CAP_RISE 4'h5
`define CCU_MODE_CAP_R4   4'h6
`define CCU_MODE_CAP_R16  4'h7
`define CCU_MODE_SET      4'h8
`define CCU_MODE_CLEAR    4'h9
`define CCU_MODE_PULSE    4'ha
`define CCU_MODE_PULS_CLR 4'hb

// Trigger source codes below the logic cell range
`define CCU_SRC_PIN       4'h0
`define CCU_SRC_CMP1      4'h1
`define CCU_SRC_CMP2      4'h2
`define CCU_SRC_PCHG      4'h3

// Bus responses
`define CCU_RESP_OKAY     2'h0
`define CCU_RESP_SLVERR   2'h2
`endif

// >>> ccu_pkg.sv
// Shared types of the capture/compare unit
package ccu_pkg;

	// Capture edge qualification handed to the trigger stage
	typedef enum logic [2:0] {
		EDGE_NONE,
		EDGE_FALL,
		EDGE_RISE,
		EDGE_RISE4,
		EDGE_RISE16,
		EDGE_ANY
	} capture_edge_t;

endpackage

// >>> capture_trigger.sv
// Capture source select, synchroniser, edge detector and prescaler
`timescale 1ns/1ps
`include "ccu_params.svh"
module capture_trigger #(
	parameter int PRESCALE_WIDTH = 4
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [11:0]           source_raw,
	input  wire logic [3:0]            source_select,
	input  wire ccu_pkg::capture_edge_t edge_mode,
	input  wire logic                  prescale_clear,
	output logic                       capture_event
);

	if (PRESCALE_WIDTH < 4) begin : g_check
		$error("capture_trigger: PRESCALE_WIDTH must be at least 4");
	end

	typedef struct packed {
		logic [11:0]               sync1;
		logic [11:0]               sync2;
		logic                      prev;
		logic [PRESCALE_WIDTH-1:0] count;
		logic                      event_out;
	} trig_state_t;

	trig_state_t state_reg;
	trig_state_t state_next;
	logic        level;
	logic        rise;
	logic        fall;
	logic        fire;
	logic        prescaled;

	// Pick the synchronised source; reserved codes read as low
	always_comb begin
		case (source_select)
			`CCU_SRC_PIN:  level = state_reg.sync2[0];
			`CCU_SRC_CMP1: level = state_reg.sync2[1];
			`CCU_SRC_CMP2: level = state_reg.sync2[2];
			`CCU_SRC_PCHG: level = state_reg.sync2[3];
			default:       level = source_select[3] &
				state_reg.sync2[4 + {29'h0, source_select[2:0]}];
		endcase
	end

	// Edge detection by comparing successive samples
	assign rise = level & ~state_reg.prev;
	assign fall = ~level & state_reg.prev;
	assign prescaled = (edge_mode == ccu_pkg::EDGE_RISE4) ||
		(edge_mode == ccu_pkg::EDGE_RISE16);

	// Qualify the edge by mode and prescaler position
	always_comb begin
		case (edge_mode)
			ccu_pkg::EDGE_FALL:   fire = fall;
			ccu_pkg::EDGE_RISE:   fire = rise;
			ccu_pkg::EDGE_RISE4:  fire = rise &
				(state_reg.count[1:0] == 2'h3);
			ccu_pkg::EDGE_RISE16: fire = rise &
				(state_reg.count[3:0] == 4'hf);
			ccu_pkg::EDGE_ANY:    fire = rise | fall;
			default:              fire = 1'b0;
		endcase
	end

	// Next state: two-stage synchroniser, prescale count, event
	always_comb begin
		state_next = state_reg;
		state_next.sync1 = source_raw;
		state_next.sync2 = state_reg.sync1;
		state_next.prev = level;
		state_next.event_out = fire;
		if (prescale_clear) begin
			state_next.count = '0;
		end else if (rise && prescaled) begin
			// A prescaler switch keeps the count running
			state_next.count = state_reg.count + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign capture_event = state_reg.event_out;

endmodule

// >>> compare_action.sv
// Compare match output latch and timer clear request
`timescale 1ns/1ps
`include "ccu_params.svh"
module compare_action (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [3:0] mode,
	input  wire logic       match,
	input  wire logic       force_low,
	output logic            compare_out,
	output logic            clear_request,
	output logic            convert_request
);

	typedef struct packed {
		logic out;
		logic pulse_armed;
		logic clear_req;
		logic convert;
	} act_state_t;

	act_state_t state_reg;
	act_state_t state_next;

	// Act on a match; a zero control write wins over the match for the output latch
	always_comb begin
		state_next = state_reg;
		state_next.clear_req = 1'b0;
		state_next.convert = match;
		state_next.pulse_armed = 1'b0;
		if (state_reg.pulse_armed) begin
			state_next.out = 1'b0;
		end
		if (match) begin
			case (mode)
				`CCU_MODE_TOG_CLR: begin
					state_next.out = ~state_reg.out;
					state_next.clear_req = 1'b1;
				end
				`CCU_MODE_TOGGLE: state_next.out = ~state_reg.out;
				`CCU_MODE_SET:    state_next.out = 1'b1;
				`CCU_MODE_CLEAR:  state_next.out = 1'b0;
				`CCU_MODE_PULSE: begin
					state_next.out = 1'b1;
					state_next.pulse_armed = 1'b1;
				end
				`CCU_MODE_PULS_CLR: begin
					state_next.out = 1'b1;
					state_next.pulse_armed = 1'b1;
					state_next.clear_req = 1'b1;
				end
				default: state_next.out = state_reg.out;
			endcase
		end
		if (force_low) begin
			state_next.out = 1'b0;
			state_next.pulse_armed = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign compare_out = state_reg.out;
	assign clear_request = state_reg.clear_req;
	assign convert_request = state_reg.convert;

endmodule

// >>> capture_compare_unit.sv
// Capture/compare unit with its AXI4-Lite register slave
`timescale 1ns/1ps
`include "ccu_params.svh"
module capture_compare_unit #(
	parameter int COUNT_WIDTH    = 16,
	parameter int ADDR_WIDTH     = 8,
	parameter int PRESCALE_WIDTH = 4
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [ADDR_WIDTH-1:0] awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [ADDR_WIDTH-1:0] araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	input  wire logic                  capture_pin,
	input  wire logic                  comparator_one_output,
	input  wire logic                  comparator_two_output,
	input  wire logic                  pin_change_interrupt,
	input  wire logic [7:0]            logic_cell_output,
	input  wire logic [2:0][15:0]      timebase_count,
	input  wire logic [2:0]            timer_sync_mode,
	output logic [2:0]                 timer_clear,
	output logic                       compare_out,
	output logic                       conversion_trigger,
	output logic                       unit_event_flag,
	output logic                       unit_event_enable
);

	// Elaboration checks on parameters the logic cannot serve
	if (COUNT_WIDTH != 16) begin : g_check_count
		$error("capture_compare_unit: COUNT_WIDTH must be 16");
	end
	if (ADDR_WIDTH < 5) begin : g_check_addr
		$error("capture_compare_unit: ADDR_WIDTH must be >= 5");
	end

	// Register indices returned by the address decoder
	localparam logic [2:0] IDX_CONTROL = 3'h0;
	localparam logic [2:0] IDX_LOW     = 3'h1;
	localparam logic [2:0] IDX_HIGH    = 3'h2;
	localparam logic [2:0] IDX_TSEL    = 3'h3;
	localparam logic [2:0] IDX_FLAG    = 3'h4;
	localparam logic [2:0] IDX_ENABLE  = 3'h5;
	localparam logic [2:0] IDX_NONE    = 3'h7;

	typedef struct packed {
		logic [11:0]           control;
		logic [15:0]           value;
		logic [1:0]            tsel;
		logic                  flag;
		logic                  enable;
		logic                  aw_held;
		logic [ADDR_WIDTH-1:0] aw_addr;
		logic                  w_held;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
		logic                  match_prev;
	} unit_state_t;

	unit_state_t state_reg;
	unit_state_t state_next;

	// Map a byte address onto a register index
	function automatic logic [2:0] reg_index(
		input logic [ADDR_WIDTH-1:0] addr
	);
		logic [ADDR_WIDTH-1:0] a;
		a = addr;
		if (a == ADDR_WIDTH'(`CCU_OFF_CONTROL)) begin
			reg_index = IDX_CONTROL;
		end else if (a == ADDR_WIDTH'(`CCU_OFF_VALUE_LOW)) begin
			reg_index = IDX_LOW;
		end else if (a == ADDR_WIDTH'(`CCU_OFF_VALUE_HI)) begin
			reg_index = IDX_HIGH;
		end else if (a == ADDR_WIDTH'(`CCU_OFF_TSEL)) begin
			reg_index = IDX_TSEL;
		end else if (a == ADDR_WIDTH'(`CCU_OFF_FLAG)) begin
			reg_index = IDX_FLAG;
		end else if (a == ADDR_WIDTH'(`CCU_OFF_ENABLE)) begin
			reg_index = IDX_ENABLE;
		end else begin
			reg_index = IDX_NONE;
		end
	endfunction

	// Timer select code to timer slot; the reserved code means the first
	function automatic logic [1:0] timer_slot(input logic [1:0] tsel);
		case (tsel)
			2'h2:    timer_slot = 2'h1;
			2'h3:    timer_slot = 2'h2;
			default: timer_slot = 2'h0;
		endcase
	endfunction

	// Capture edge implied by a mode code; others are not capture
	function automatic ccu_pkg::capture_edge_t mode_edge(
		input logic [3:0] mode
	);
		case (mode)
			`CCU_MODE_CAP_ANY:  mode_edge = ccu_pkg::EDGE_ANY;
			`CCU_MODE_CAP_FALL: mode_edge = ccu_pkg::EDGE_FALL;
			`CCU_MODE_CAP_RISE: mode_edge = ccu_pkg::EDGE_RISE;
			`CCU_MODE_CAP_R4:   mode_edge = ccu_pkg::EDGE_RISE4;
			`CCU_MODE_CAP_R16:  mode_edge = ccu_pkg::EDGE_RISE16;
			default:            mode_edge = ccu_pkg::EDGE_NONE;
		endcase
	endfunction

	// True for the six compare action codes
	function automatic logic is_compare(input logic [3:0] mode);
		case (mode)
			`CCU_MODE_TOG_CLR, `CCU_MODE_TOGGLE, `CCU_MODE_SET,
			`CCU_MODE_CLEAR, `CCU_MODE_PULSE, `CCU_MODE_PULS_CLR:
				is_compare = 1'b1;
			default: is_compare = 1'b0;
		endcase
	endfunction

	logic [3:0]             mode;
	logic                   unit_on;
	logic [1:0]             slot;
	logic [15:0]            count;
	logic                   timer_ok;
	ccu_pkg::capture_edge_t edge_mode;
	logic                   capture_event;
	logic                   capture_take;
	logic                   match_now;
	logic                   match;
	logic                   write_now;
	logic [2:0]             write_idx;
	logic                   zero_write;
	logic                   clear_request;
	logic                   convert_request;
	logic [11:0]            control_written;

	// Control decode and selected timer
	assign mode = state_reg.control[`CCU_CTL_MODE_MSB:`CCU_CTL_MODE_LSB];
	assign unit_on = state_reg.control[`CCU_CTL_ON_BIT];
	assign slot = timer_slot(state_reg.tsel);
	assign count = timebase_count[slot];
	// Async-counter timers are not served
	assign timer_ok = timer_sync_mode[slot];
	assign edge_mode = unit_on ? mode_edge(mode) : ccu_pkg::EDGE_NONE;

	// Trigger stage; mode changes are not masked, so they may fire
	capture_trigger #(
		.PRESCALE_WIDTH (PRESCALE_WIDTH)
	) u_trigger (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.source_raw     ({logic_cell_output, pin_change_interrupt,
			comparator_two_output, comparator_one_output,
			capture_pin}),
		.source_select  (state_reg.control[`CCU_CTL_SRC_MSB:
			`CCU_CTL_SRC_LSB]),
		.edge_mode      (edge_mode),
		.prescale_clear (edge_mode == ccu_pkg::EDGE_NONE),
		.capture_event  (capture_event)
	);

	// Capture is not gated by sleep, only by the timer mode and an active capture mode
	assign capture_take = capture_event & timer_ok &
		(edge_mode != ccu_pkg::EDGE_NONE);

	// Continuous compare; act once as equality begins
	assign match_now = unit_on & is_compare(mode) & timer_ok &
		(state_reg.value == count);
	assign match = match_now & ~state_reg.match_prev;

	// Pending write and the control value it would leave
	assign write_now = state_reg.aw_held & state_reg.w_held;
	assign write_idx = reg_index(state_reg.aw_addr);
	assign control_written = {
		state_reg.w_strb[1] ? state_reg.w_data[11:8] :
			state_reg.control[11:8],
		state_reg.w_strb[0] ? state_reg.w_data[7:0] :
			state_reg.control[7:0]};
	assign zero_write = write_now && (write_idx == IDX_CONTROL) &&
		(control_written == 12'h000);

	compare_action u_action (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.mode            (mode),
		.match           (match),
		.force_low       (zero_write),
		.compare_out     (compare_out),
		.clear_request   (clear_request),
		.convert_request (convert_request)
	);

	// Bus handshakes, register writes, captures and the event flag
	always_comb begin
		state_next = state_reg;
		state_next.match_prev = match_now;
		if (awvalid && awready) begin
			state_next.aw_held = 1'b1;
			state_next.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			state_next.w_held = 1'b1;
			state_next.w_data = wdata;
			state_next.w_strb = wstrb;
		end
		if (bvalid && bready) begin
			state_next.bvalid = 1'b0;
		end
		if (write_now) begin
			state_next.aw_held = 1'b0;
			state_next.w_held = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = (write_idx == IDX_NONE) ?
				`CCU_RESP_SLVERR : `CCU_RESP_OKAY;
			case (write_idx)
				IDX_CONTROL: state_next.control = control_written;
				IDX_LOW: if (state_reg.w_strb[0]) begin
					state_next.value[7:0] = state_reg.w_data[7:0];
				end
				IDX_HIGH: if (state_reg.w_strb[0]) begin
					state_next.value[15:8] = state_reg.w_data[7:0];
				end
				IDX_TSEL: if (state_reg.w_strb[0]) begin
					state_next.tsel = state_reg.w_data[1:0];
				end
				IDX_FLAG: if (state_reg.w_strb[0] &&
					!state_reg.w_data[0]) begin
					state_next.flag = 1'b0;
				end
				IDX_ENABLE: if (state_reg.w_strb[0]) begin
					state_next.enable = state_reg.w_data[0];
				end
				default: state_next.bresp = `CCU_RESP_SLVERR;
			endcase
		end
		// Capture after any write: newest count always lands
		if (capture_take) begin
			state_next.value = count;
		end
		// Hardware set wins over a software clear
		if (capture_take || match) begin
			state_next.flag = 1'b1;
		end
		if (rvalid && rready) begin
			state_next.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			state_next.rvalid = 1'b1;
			state_next.rresp = `CCU_RESP_OKAY;
			state_next.rdata = 32'h0000_0000;
			case (reg_index(araddr))
				IDX_CONTROL: state_next.rdata[11:0] = state_reg.control;
				IDX_LOW:  state_next.rdata[7:0] = state_reg.value[7:0];
				IDX_HIGH: state_next.rdata[7:0] = state_reg.value[15:8];
				IDX_TSEL: state_next.rdata[1:0] = state_reg.tsel;
				IDX_FLAG: state_next.rdata[0] = state_reg.flag;
				IDX_ENABLE: state_next.rdata[0] = state_reg.enable;
				default: state_next.rresp = `CCU_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
			state_reg.control <= `CCU_CONTROL_RESET;
			state_reg.tsel <= `CCU_TSEL_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// Bus ready terms: one write and one read in flight
	assign awready = ~state_reg.aw_held & ~state_reg.bvalid;
	assign wready = ~state_reg.w_held & ~state_reg.bvalid;
	assign arready = ~state_reg.rvalid;
	assign bvalid = state_reg.bvalid;
	assign bresp = state_reg.bresp;
	assign rvalid = state_reg.rvalid;
	assign rdata = state_reg.rdata;
	assign rresp = state_reg.rresp;

	// Timer clear goes to the timer selected now
	assign timer_clear = clear_request ? (3'h1 << slot) : 3'h0;
	assign conversion_trigger = convert_request;
	assign unit_event_flag = state_reg.flag;
	assign unit_event_enable = state_reg.enable;

endmodule

// >>> capture_compare_unit_chk.sv
// Concurrent property checker for the capture/compare unit
`timescale 1ns/1ps
module capture_compare_unit_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	input wire logic [2:0]  timer_clear,
	input wire logic        compare_out,
	input wire logic        conversion_trigger,
	input wire logic        unit_event_flag
);
	// Single clock domain, reset disables every property
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Flag and match side effects
	a_flag_sticky: assert property (
		$fell(unit_event_flag) |-> $rose(bvalid))
		else $error("event flag dropped without a bus write");
	a_match_flag: assert property (
		conversion_trigger |-> unit_event_flag)
		else $error("conversion trigger without event flag");
	a_trig_single: assert property (
		conversion_trigger |=> !conversion_trigger)
		else $error("conversion trigger longer than one cycle");
	a_clear_match: assert property (
		(|timer_clear) |-> conversion_trigger && $onehot(timer_clear))
		else $error("timer clear without a single compare match");
	a_out_rise: assert property (
		$rose(compare_out) |-> conversion_trigger)
		else $error("compare output rose without a match");
	a_out_fall: assert property (
		$fell(compare_out) |->
		conversion_trigger || $past(conversion_trigger) || $rose(bvalid))
		else $error("compare output fell without cause");

	// Register bus answers
	a_write_answer: assert property (
		awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response not two cycles after acceptance");
	a_read_answer: assert property (
		arvalid && arready |=> rvalid)
		else $error("read data not one cycle after acceptance");
	a_read_hold: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata) && !arready)
		else $error("read data changed before it was taken");

	// Main scenarios reached
	c_pulse: cover property (conversion_trigger && compare_out);
	c_capture: cover property ($rose(unit_event_flag));
	c_clear: cover property (|timer_clear);
endmodule

bind capture_compare_unit capture_compare_unit_chk i_chk (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
	.timer_clear(timer_clear), .compare_out(compare_out),
	.conversion_trigger(conversion_trigger),
	.unit_event_flag(unit_event_flag)
);

// >>> timebase_model.sv
// Model of the three timebases that feed the unit
`timescale 1ns/1ps
module timebase_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        hold,
	input  wire logic [2:0]  timer_clear,
	output logic [2:0][15:0] timebase_count,
	output logic [2:0]       timer_sync_mode
);
	// All timers run synchronised from the unit clock
	assign timer_sync_mode = 3'h7;

	// Count each cycle; hold freezes as in sleep; clear request zeroes
	always_ff @(posedge aclk) begin
		for (int i = 0; i < 3; i++) begin
			if (!aresetn)
				timebase_count[i] <= 16'(i) << 12;
			else if (timer_clear[i])
				timebase_count[i] <= 16'h0000;
			else if (!hold)
				timebase_count[i] <= timebase_count[i] + 16'h0001;
		end
	end
endmodule

// >>> capture_compare_unit_tb.sv
// Self-checking testbench for the capture/compare unit
`timescale 1ns/1ps
`include "ccu_params.svh"
module capture_compare_unit_tb;
	logic             aclk, aresetn, hold, cmp_out, conv, flag, ien;
	logic             awvalid, awready, wvalid, wready, bvalid, bready;
	logic             arvalid, arready, rvalid, rready;
	logic [7:0]       awaddr, araddr;
	logic [31:0]      wdata, rdata, rd;
	logic [3:0]       wstrb;
	logic [1:0]       bresp, rresp, rr;
	logic [11:0]      src_v;
	logic [2:0][15:0] cnt;
	logic [2:0]       sync_m, tclr;
	integer           seed;
	int               bad_count;
	int               total_checks;

	// Clock at 20 MHz
	initial aclk = 1'b0;
	always #25 aclk = ~aclk;

	capture_compare_unit i_dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.capture_pin(src_v[0]), .comparator_one_output(src_v[1]),
		.comparator_two_output(src_v[2]), .pin_change_interrupt(src_v[3]),
		.logic_cell_output(src_v[11:4]), .timebase_count(cnt),
		.timer_sync_mode(sync_m), .timer_clear(tclr), .compare_out(cmp_out),
		.conversion_trigger(conv), .unit_event_flag(flag),
		.unit_event_enable(ien));
	timebase_model i_tmr (.aclk(aclk), .aresetn(aresetn), .hold(hold),
		.timer_clear(tclr), .timebase_count(cnt), .timer_sync_mode(sync_m));

	// Verdict and end of run
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic stall();
		bad_count++;
		$display("FAIL wait expected answer seen timeout");
		final_report();
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Bus write: address and data offered together, held until taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!bvalid && n < 100);
		bready <= 1'b0;
		if (n >= 100)
			stall();
		chk("bresp", 32'(er), 32'(bresp));
	endtask

	// Bus read: result left in rd and rr
	task automatic rdreg(input logic [7:0] a);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && !rready)
				rready <= 1'b1;
		end while (!(rvalid && rready) && n < 100);
		rready <= 1'b0;
		rd = rdata;
		rr = rresp;
		if (n >= 100)
			stall();
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rdreg(a);
		chk("rdata", e, rd);
		chk("rresp", 32'(`CCU_RESP_OKAY), 32'(rr));
	endtask

	task automatic rdv(input logic [15:0] e);
		rchk(`CCU_OFF_VALUE_LOW, 32'(e[7:0]));
		rchk(`CCU_OFF_VALUE_HI, 32'(e[15:8]));
	endtask

	task automatic tog(input int b);
		src_v[b] <= ~src_v[b];
		repeat (6) @(posedge aclk);
	endtask

	function automatic logic [31:0] ctl(input logic [3:0] m,
			input logic [3:0] s);
		return {20'h0, s, 1'b1, 3'h0, m};
	endfunction

	// Toggle index, from a low source, of the first capture (0 = never)
	function automatic int first_cap(input logic [3:0] m,
			input logic [3:0] s);
		if (s inside {[4'h4:4'h7]})
			return 0;
		case (m)
			`CCU_MODE_CAP_FALL: return 2;
			`CCU_MODE_CAP_R4:   return 7;
			`CCU_MODE_CAP_R16:  return 31;
			default:            return 1;
		endcase
	endfunction

	function automatic int src_bit(input logic [3:0] s);
		return s[3] ? int'(s) - 4 : (s > 4'h3 ? 0 : int'(s));
	endfunction

	function automatic logic [15:0] after_match(input logic [3:0] m,
			input logic [15:0] v);
		if (m == `CCU_MODE_TOG_CLR || m == `CCU_MODE_PULS_CLR)
			return 16'h0000;
		return v + 16'h0002;
	endfunction

	// One capture configuration: no early event, then value from timer
	task automatic cap_test(input logic [3:0] m, input logic [3:0] s,
			input logic [1:0] ts);
		int f;
		int b;
		f = first_cap(m, s);
		b = src_bit(s);
		hold <= 1'b0;
		src_v <= 12'h000;
		repeat (1 + {$random(seed)} % 40) @(posedge aclk);
		hold <= 1'b1;
		wr(`CCU_OFF_TSEL, 32'(ts), `CCU_RESP_OKAY);
		wr(`CCU_OFF_CONTROL, 32'h0, `CCU_RESP_OKAY);
		wr(`CCU_OFF_CONTROL, ctl(m, s), `CCU_RESP_OKAY);
		wr(`CCU_OFF_FLAG, 32'h0, `CCU_RESP_OKAY);
		for (int k = 1; k <= (f > 0 ? f : 2); k++) begin
			tog(b);
			chk("flag", 32'(k == f), 32'(flag));
		end
		if (f > 0)
			rdv(cnt[ts == 2'h0 ? 0 : int'(ts) - 1]);
		$display("capture mode %h source %h done", m, s);
	endtask

	// One compare action: latch, flag and timer after the match
	task automatic cmp_test(input logic [3:0] m, input logic e);
		int n;
		logic [15:0] v;
		hold <= 1'b0;
		wr(`CCU_OFF_CONTROL, 32'h80, `CCU_RESP_OKAY);
		wr(`CCU_OFF_FLAG, 32'h0, `CCU_RESP_OKAY);
		v = cnt[0] + 16'd80 + 16'({$random(seed)} % 200);
		wr(`CCU_OFF_VALUE_LOW, 32'(v[7:0]), `CCU_RESP_OKAY);
		wr(`CCU_OFF_VALUE_HI, 32'(v[15:8]), `CCU_RESP_OKAY);
		wr(`CCU_OFF_CONTROL, ctl(m, `CCU_SRC_PIN), `CCU_RESP_OKAY);
		n = 0;
		while (!conv && n < 400) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 400)
			stall();
		chk("flag", 32'h1, 32'(flag));
		chk("latch", 32'(e), 32'(cmp_out));
		@(posedge aclk);
		chk("count", 32'(after_match(m, v)), 32'(cnt[0]));
		if (m == `CCU_MODE_PULSE || m == `CCU_MODE_PULS_CLR)
			chk("pulse", 32'h0, 32'(cmp_out));
		$display("compare mode %h done", m);
	endtask

	initial begin
		seed = 32'h449d07de;
		bad_count = 0;
		total_checks = 0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, hold} = '0;
		{awaddr, araddr, wdata, wstrb, src_v} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(`CCU_OFF_CONTROL, 32'h0);
		rchk(`CCU_OFF_TSEL, 32'h1);
		rchk(`CCU_OFF_FLAG, 32'h0);
		wr(`CCU_OFF_ENABLE, 32'h1, `CCU_RESP_OKAY);
		chk("enable", 32'h1, 32'(ien));
		rchk(`CCU_OFF_ENABLE, 32'h1);
		wr(8'h18, $random(seed), `CCU_RESP_SLVERR);
		rdreg(8'h18);
		chk("rdata", 32'h0, rd);
		chk("rresp", 32'(`CCU_RESP_SLVERR), 32'(rr));
		$display("register access test done");
		cap_test(`CCU_MODE_CAP_RISE, `CCU_SRC_PIN, 2'h1);
		cap_test(`CCU_MODE_CAP_FALL, `CCU_SRC_CMP1, 2'h2);
		cap_test(`CCU_MODE_CAP_ANY, `CCU_SRC_CMP2, 2'h3);
		// Second event replaces the value already read, without any mark
		hold <= 1'b0;
		repeat (9) @(posedge aclk);
		hold <= 1'b1;
		tog(2);
		rdv(cnt[2]);
		wr(`CCU_OFF_FLAG, 32'h1, `CCU_RESP_OKAY);
		chk("flag", 32'h1, 32'(flag));
		cap_test(`CCU_MODE_CAP_R16, `CCU_SRC_PCHG, 2'h1);
		cap_test(`CCU_MODE_CAP_RISE, 4'hf, 2'h2);
		cap_test(`CCU_MODE_CAP_RISE, 4'h8, 2'h3);
		cap_test(`CCU_MODE_CAP_RISE, 4'h5, 2'h1);
		// Half-counted prescaler is lost when the unit is switched off
		src_v <= 12'h000;
		wr(`CCU_OFF_CONTROL, ctl(`CCU_MODE_CAP_R4, `CCU_SRC_PIN),
			`CCU_RESP_OKAY);
		repeat (4) tog(0);
		cap_test(`CCU_MODE_CAP_R4, `CCU_SRC_PIN, 2'h1);
		wr(`CCU_OFF_CONTROL, 32'h0, `CCU_RESP_OKAY);
		cmp_test(`CCU_MODE_SET, 1'b1);
		cmp_test(`CCU_MODE_CLEAR, 1'b0);
		cmp_test(`CCU_MODE_TOGGLE, 1'b1);
		cmp_test(`CCU_MODE_TOG_CLR, 1'b0);
		cmp_test(`CCU_MODE_PULSE, 1'b1);
		cmp_test(`CCU_MODE_PULS_CLR, 1'b1);
		cmp_test(`CCU_MODE_SET, 1'b1);
		wr(`CCU_OFF_CONTROL, 32'h0, `CCU_RESP_OKAY);
		chk("latch", 32'h0, 32'(cmp_out));
		final_report();
	end
endmodule
